/* File: rtl/draw_regs_pkg.sv */
// Purpose: Shared constants for the drawing engine index register bank.
// Assumes: 16-bit host data path and a 200 MHz engine clock.
// Notes:   Port addresses are the printed I/O addresses.
`default_nettype none
package draw_regs_pkg;
  localparam logic [15:0] INDEX_PORT_ADDR   = 16'hBEE8;
  localparam logic [15:0] PIXEL_PORT_ADDR   = 16'hE2E8;
  localparam logic [15:0] PIXEL_HIGH_ADDR   = 16'hE2EA;
  localparam int          INDEX_MSB         = 15;
  localparam int          INDEX_LSB         = 12;
  localparam logic [3:0]  IDX_CLIP_BOTTOM   = 4'h3;
  localparam logic [3:0]  IDX_CLIP_RIGHT    = 4'h4;
  localparam logic [3:0]  IDX_MIX_SELECT    = 4'hA;
  localparam logic [3:0]  IDX_EXT_BASE      = 4'hD;
  localparam logic [3:0]  IDX_MISC          = 4'hE;
  localparam logic [3:0]  IDX_READ_SELECT   = 4'hF;
  localparam logic [15:0] EXT_BASE_RESET    = 16'hDC00;
  localparam logic [15:0] MISC_RESET        = 16'hE000;
  localparam int          MIX_LSB           = 6;
  localparam int          XDST_LSB          = 0;
  localparam int          XSRC_LSB          = 4;
  localparam int          NDST_LSB          = 0;
  localparam int          NSRC_LSB          = 2;
  localparam int          UPPER_WORD_BIT    = 4;
  localparam int          OUTSIDE_CLIP_BIT  = 5;
  localparam int          CMP_POLARITY_BIT  = 7;
  localparam int          CMP_ENABLE_BIT    = 8;
  localparam int          CMD_WIDTH32_BIT   = 9;
  localparam int          EDO_DISABLE_BIT   = 10;
  localparam logic [11:0] MIX_WRITE_MASK    = 12'h0C0;
  localparam logic [11:0] EXT_BASE_MASK     = 12'h077;
  localparam logic [11:0] MISC_MASK         = 12'h7BF;
  localparam logic [3:0]  SEL_MIX           = 4'h5;
  localparam logic [3:0]  SEL_MISC          = 4'h6;
  localparam logic [3:0]  SEL_COMMAND       = 4'h7;
  localparam logic [3:0]  SEL_SUBSYS        = 4'h8;
  localparam logic [3:0]  SEL_VIDEO_ENABLE  = 4'h9;
  localparam logic [3:0]  SEL_EXT_BASE      = 4'hA;
  localparam logic [15:0] COMMAND_READ_MASK = 16'h1FFF;
  localparam logic [15:0] SUBSYS_READ_MASK  = 16'h0FFF;
endpackage
`default_nettype wire

/* File: rtl/pixel_xfer_if.sv */
// Purpose: Carries pixel port writes to the transfer assembler and its beats back.
// Assumes: All signals on the engine clock.
// Notes:   The bank drives the write side, the assembler the beat side.
`default_nettype none
interface pixel_xfer_if;
  logic        low_wr;
  logic        high_wr;
  logic        wide_mode;
  logic [15:0] wdata;
  logic        beat_valid;
  logic        beat_wide;
  logic [31:0] beat_data;
  modport bank (output low_wr, output high_wr, output wide_mode, output wdata,
                input beat_valid, input beat_wide, input beat_data);
  modport assembler (input low_wr, input high_wr, input wide_mode, input wdata,
                     output beat_valid, output beat_wide, output beat_data);
endinterface
`default_nettype wire

/* File: rtl/pixel_transfer_assembler.sv */
// Purpose: Joins pixel port half-words into 16- or 32-bit image beats.
// Assumes: At most one port write per cycle.
// Notes:   A high half with no pending low half is dropped.
`default_nettype none
module pixel_transfer_assembler (
  input  wire logic clock_i,        // Engine clock.
  input  wire logic nrst_i,         // Asynchronous reset, active low.
  pixel_xfer_if.assembler xfer      // Port writes in, beats out.
);
  logic [15:0] low_q;
  logic        pending_q;
  logic        beat_valid_q;
  logic        beat_wide_q;
  logic [31:0] beat_data_q;
  wire         emit_narrow = xfer.low_wr && !xfer.wide_mode;
  wire         emit_wide   = xfer.high_wr && pending_q;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_q        <= 16'h0000;
      pending_q    <= 1'b0;
      beat_valid_q <= 1'b0;
      beat_wide_q  <= 1'b0;
      beat_data_q  <= 32'h0000_0000;
    end else begin
      beat_valid_q <= emit_narrow || emit_wide;
      if (xfer.low_wr) begin
        low_q     <= xfer.wdata;
        pending_q <= xfer.wide_mode;
      end else if (xfer.high_wr) begin
        pending_q <= 1'b0;
      end
      if (emit_narrow) begin
        beat_wide_q <= 1'b0;
        beat_data_q <= {16'h0000, xfer.wdata};
      end else if (emit_wide) begin
        beat_wide_q <= 1'b1;
        beat_data_q <= {xfer.wdata, low_q};
      end
    end
  end

  assign xfer.beat_valid = beat_valid_q;
  assign xfer.beat_wide  = beat_wide_q;
  assign xfer.beat_data  = beat_data_q;
endmodule
`default_nettype wire

/* File: rtl/draw_engine_index_regs.sv */
// Purpose: Index-multiplexed configuration bank of a 2D drawing engine.
// Assumes: Host strobes are synchronous to clock_i, one access per cycle.
// Notes:   Indexed writes other than read-select commit one cycle after the host write.
`default_nettype none
module draw_engine_index_regs (
  input  wire logic        clock_i,             // Engine clock, 200 MHz.
  input  wire logic        nrst_i,              // Asynchronous reset, active low.
  input  wire logic [15:0] io_addr_i,           // Host port address.
  input  wire logic        io_wr_i,             // Host write strobe.
  input  wire logic        io_rd_i,             // Host read strobe.
  input  wire logic [15:0] io_wdata_i,          // Host write data.
  input  wire logic        io_mmio_i,           // Current access is memory mapped.
  input  wire logic        bpp32_i,             // Engine is in 32 bpp mode.
  input  wire logic        half_access_i,       // One 16-bit half of a 32-bit register was accessed.
  input  wire logic [15:0] minor_count_i,       // Readback of index 0.
  input  wire logic [15:0] clip_top_i,          // Top clip register, readback of index 1.
  input  wire logic [15:0] clip_left_i,         // Left clip register, readback of index 2.
  input  wire logic [15:0] command_i,           // Drawing command register.
  input  wire logic [15:0] subsys_status_i,     // Subsystem status register.
  input  wire logic [15:0] video_enable_i,      // Video subsystem enable register.
  input  wire logic [11:0] pixel_x_i,           // Candidate pixel column.
  input  wire logic [11:0] pixel_y_i,           // Candidate pixel row.
  input  wire logic [31:0] source_colour_i,     // Source colour of the pixel.
  input  wire logic [31:0] compare_colour_i,    // Colour compare register value.
  output logic      [15:0] io_rdata_o,          // Readback data, valid the cycle after the read.
  output logic      [11:0] clip_bottom_o,       // Bottom clip limit.
  output logic      [11:0] clip_right_o,        // Right clip limit.
  output logic      [1:0]  mix_register_chooser_o, // Mix register selection mode.
  output logic      [2:0]  destination_megabyte_o, // Effective destination megabyte.
  output logic      [2:0]  source_megabyte_o,   // Effective source megabyte.
  output logic             upper_word_flag_o,   // High half selected for 32-bit registers.
  output logic             outside_clip_enable_o, // Draw outside the clip rectangle.
  output logic             colour_compare_enable_o, // Colour compare enabled.
  output logic             compare_polarity_o,  // Skip on inequality when set.
  output logic             command_width_32_o,  // Command registers are 32-bit for this access.
  output logic             edo_single_cycle_o,  // Single-cycle EDO allowed.
  output logic             draw_permit_o,       // Pixel passes the clip test.
  output logic             update_permit_o,     // Pixel passes the colour compare.
  output logic             pixel_valid_o,       // Image data beat valid, one-cycle pulse.
  output logic             pixel_wide_o,        // Beat carries 32 bits.
  output logic      [31:0] pixel_data_o         // Image data beat.
);
  logic [11:0] clip_bottom_q;
  logic [11:0] clip_right_q;
  logic [11:0] mix_q;
  logic [11:0] ext_base_q;
  logic [11:0] misc_q;
  logic [3:0]  read_index_q;
  logic        pipe_valid_q;
  logic [15:0] pipe_data_q;
  logic [15:0] rdata_q;
  logic        width32_q;
  logic        draw_q;
  logic        update_q;
  logic [2:0]  dst_q;
  logic [2:0]  src_q;
  logic        edo_q;

  pixel_xfer_if xfer ();

  wire        index_wr   = io_wr_i && (io_addr_i == draw_regs_pkg::INDEX_PORT_ADDR);
  wire        index_rd   = io_rd_i && (io_addr_i == draw_regs_pkg::INDEX_PORT_ADDR);
  wire [3:0]  wr_index   = io_wdata_i[draw_regs_pkg::INDEX_MSB:draw_regs_pkg::INDEX_LSB];
  wire [3:0]  pipe_index = pipe_data_q[draw_regs_pkg::INDEX_MSB:draw_regs_pkg::INDEX_LSB];
  wire [11:0] pipe_value = pipe_data_q[11:0];
  wire        sel_wr     = index_wr && (wr_index == draw_regs_pkg::IDX_READ_SELECT);
  wire        commit_misc = pipe_valid_q && (pipe_index == draw_regs_pkg::IDX_MISC);
  wire        toggle_ok  = half_access_i && bpp32_i
                           && !misc_q[draw_regs_pkg::CMD_WIDTH32_BIT];

  wire [2:0]  wide_dst   = ext_base_q[draw_regs_pkg::XDST_LSB +: 3];
  wire [2:0]  wide_src   = ext_base_q[draw_regs_pkg::XSRC_LSB +: 3];
  wire [1:0]  narrow_dst = misc_q[draw_regs_pkg::NDST_LSB +: 2];
  wire [1:0]  narrow_src = misc_q[draw_regs_pkg::NSRC_LSB +: 2];
  // A wide field of zero hands control back to the narrow field.
  // wide destination and source override
  wire [2:0]  eff_dst    = (wide_dst != 3'h0) ? wide_dst : {1'b0, narrow_dst};
  wire [2:0]  eff_src    = (wide_src != 3'h0) ? wide_src : {1'b0, narrow_src};

  // Top and left limits live outside this bank; only their low 12 bits are compared.
  // inclusive clip window
  wire        in_window  = (pixel_y_i >= clip_top_i[11:0]) && (pixel_y_i <= clip_bottom_q)
                           && (pixel_x_i >= clip_left_i[11:0]) && (pixel_x_i <= clip_right_q);
  wire        colour_eq  = (source_colour_i == compare_colour_i);
  wire        cmp_pass   = !misc_q[draw_regs_pkg::CMP_ENABLE_BIT]
                           || (misc_q[draw_regs_pkg::CMP_POLARITY_BIT] ? colour_eq : !colour_eq);

  logic [15:0] read_mux;
  always_comb begin
    case (read_index_q)
      4'h0:                            read_mux = minor_count_i;
      4'h1:                            read_mux = clip_top_i;
      4'h2:                            read_mux = clip_left_i;
      4'h3:                            read_mux = {draw_regs_pkg::IDX_CLIP_BOTTOM, clip_bottom_q};
      4'h4:                            read_mux = {draw_regs_pkg::IDX_CLIP_RIGHT, clip_right_q};
      draw_regs_pkg::SEL_MIX:          read_mux = {draw_regs_pkg::IDX_MIX_SELECT, mix_q};
      draw_regs_pkg::SEL_MISC:         read_mux = {draw_regs_pkg::IDX_MISC, misc_q};
      draw_regs_pkg::SEL_COMMAND:      read_mux = command_i & draw_regs_pkg::COMMAND_READ_MASK;
      draw_regs_pkg::SEL_SUBSYS:       read_mux = subsys_status_i & draw_regs_pkg::SUBSYS_READ_MASK;
      draw_regs_pkg::SEL_VIDEO_ENABLE: read_mux = video_enable_i;
      draw_regs_pkg::SEL_EXT_BASE:     read_mux = {draw_regs_pkg::IDX_EXT_BASE, ext_base_q};
      default:                         read_mux = 16'h0000;
    endcase
  end

  // Select writes bypass the pipe, so a read may follow them at once.
  // index-routed write pipeline
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pipe_valid_q <= 1'b0;
      pipe_data_q  <= 16'h0000;
    end else begin
      pipe_valid_q <= index_wr && !sel_wr;
      pipe_data_q  <= io_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clip_bottom_q <= 12'h000;
    end else if (pipe_valid_q && pipe_index == draw_regs_pkg::IDX_CLIP_BOTTOM) begin
      clip_bottom_q <= pipe_value;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clip_right_q <= 12'h000;
    end else if (pipe_valid_q && pipe_index == draw_regs_pkg::IDX_CLIP_RIGHT) begin
      clip_right_q <= pipe_value;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mix_q <= 12'h000;
    end else if (pipe_valid_q && pipe_index == draw_regs_pkg::IDX_MIX_SELECT) begin
      mix_q <= pipe_value & draw_regs_pkg::MIX_WRITE_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_base_q <= draw_regs_pkg::EXT_BASE_RESET[11:0] & draw_regs_pkg::EXT_BASE_MASK;
    end else if (pipe_valid_q && pipe_index == draw_regs_pkg::IDX_EXT_BASE) begin
      ext_base_q <= pipe_value & draw_regs_pkg::EXT_BASE_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      misc_q <= draw_regs_pkg::MISC_RESET[11:0] & draw_regs_pkg::MISC_MASK;
    end else if (commit_misc) begin
      misc_q <= pipe_value & draw_regs_pkg::MISC_MASK;
    // A committing write outranks a toggle in the same cycle.
    end else if (toggle_ok) begin
      misc_q[draw_regs_pkg::UPPER_WORD_BIT] <= !misc_q[draw_regs_pkg::UPPER_WORD_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      read_index_q <= 4'h0;
    end else if (sel_wr) begin
      read_index_q <= io_wdata_i[3:0];
    end else if (index_rd) begin
      read_index_q <= read_index_q + 4'h1;
    end
  end

  // registered read data
  // Reads of other ports return zero rather than stale data.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 16'h0000;
    end else if (io_rd_i) begin
      rdata_q <= index_rd ? read_mux : 16'h0000;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      draw_q <= 1'b0;
    end else begin
      draw_q <= in_window ^ misc_q[draw_regs_pkg::OUTSIDE_CLIP_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      update_q <= 1'b0;
    end else begin
      update_q <= cmp_pass;
    end
  end

  // width applies to programmed I/O
  // Memory-mapped accesses always see the narrow command registers.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      width32_q <= 1'b0;
    end else begin
      width32_q <= misc_q[draw_regs_pkg::CMD_WIDTH32_BIT] && !io_mmio_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dst_q <= 3'h0;
      src_q <= 3'h0;
    end else begin
      dst_q <= eff_dst;
      src_q <= eff_src;
    end
  end

  // EDO permit register
  // The disable bit resets clear, so single-cycle EDO is allowed out of reset.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edo_q <= 1'b1;
    end else begin
      edo_q <= !misc_q[draw_regs_pkg::EDO_DISABLE_BIT];
    end
  end

  assign xfer.low_wr    = io_wr_i && (io_addr_i == draw_regs_pkg::PIXEL_PORT_ADDR);
  assign xfer.high_wr   = io_wr_i && (io_addr_i == draw_regs_pkg::PIXEL_HIGH_ADDR);
  assign xfer.wide_mode = bpp32_i;
  assign xfer.wdata     = io_wdata_i;

  pixel_transfer_assembler assembler_u (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .xfer    (xfer.assembler)
  );

  assign io_rdata_o              = rdata_q;
  assign clip_bottom_o           = clip_bottom_q;
  assign clip_right_o            = clip_right_q;
  assign mix_register_chooser_o  = mix_q[draw_regs_pkg::MIX_LSB +: 2];
  assign destination_megabyte_o  = dst_q;
  assign source_megabyte_o       = src_q;
  assign upper_word_flag_o       = misc_q[draw_regs_pkg::UPPER_WORD_BIT];
  assign outside_clip_enable_o   = misc_q[draw_regs_pkg::OUTSIDE_CLIP_BIT];
  assign colour_compare_enable_o = misc_q[draw_regs_pkg::CMP_ENABLE_BIT];
  assign compare_polarity_o      = misc_q[draw_regs_pkg::CMP_POLARITY_BIT];
  assign command_width_32_o      = width32_q;
  assign edo_single_cycle_o      = edo_q;
  assign draw_permit_o           = draw_q;
  assign update_permit_o         = update_q;
  assign pixel_valid_o           = xfer.beat_valid;
  assign pixel_wide_o            = xfer.beat_wide;
  assign pixel_data_o            = xfer.beat_data;
endmodule
`default_nettype wire

/* File: verif/draw_engine_index_regs_properties.sv */
// Purpose: Port-level checks of the index register bank.
// Assumes: One engine clock, asynchronous active-low reset.
// Notes:   Attached to the bank by the bind below.
`default_nettype none
module draw_engine_index_regs_properties (
  input wire logic        clock_i,                // Clock.
  input wire logic        nrst_i,                 // Reset.
  input wire logic [15:0] io_addr_i,              // Address.
  input wire logic        io_wr_i,                // Write.
  input wire logic        io_rd_i,                // Read.
  input wire logic [15:0] io_wdata_i,             // Data.
  input wire logic        bpp32_i,                // 32 bpp.
  input wire logic [15:0] io_rdata_o,             // Readback.
  input wire logic [11:0] clip_bottom_o,          // Bottom.
  input wire logic [11:0] clip_right_o,           // Right.
  input wire logic [1:0]  mix_register_chooser_o, // Mix.
  input wire logic        outside_clip_enable_o,  // Outside.
  input wire logic        edo_single_cycle_o,     // EDO.
  input wire logic        pixel_valid_o,          // Beat.
  input wire logic        pixel_wide_o,           // Wide.
  input wire logic [31:0] pixel_data_o            // Beat data.
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  wire iw = io_wr_i && (io_addr_i == 16'hBEE8);
  wire w3 = iw && (io_wdata_i[15:12] == 4'h3);
  wire w4 = iw && (io_wdata_i[15:12] == 4'h4);
  wire wa = iw && (io_wdata_i[15:12] == 4'hA);
  wire we = iw && (io_wdata_i[15:12] == 4'hE);
  wire lo = io_wr_i && (io_addr_i == 16'hE2E8);
  wire hi = io_wr_i && (io_addr_i == 16'hE2EA);
  chk_bottom_commit: assert property (
    w3 ##1 !w3 ##1 !w3 |-> ##1 clip_bottom_o == $past(io_wdata_i[11:0], 3)) else $error("bottom limit wrong");
  chk_right_commit: assert property (
    w4 ##1 !w4 ##1 !w4 |-> ##1 clip_right_o == $past(io_wdata_i[11:0], 3)) else $error("right limit wrong");
  chk_mix_commit: assert property (
    wa ##1 !wa ##1 !wa |-> ##1 mix_register_chooser_o == $past(io_wdata_i[7:6], 3)) else $error("mix wrong");
  chk_edo_polarity: assert property (
    we ##1 !we ##1 !we |-> ##1 edo_single_cycle_o == !$past(io_wdata_i[10], 3)) else $error("edo wrong");
  chk_outside_clip: assert property (
    we ##1 !we ##1 !we |-> ##1 outside_clip_enable_o == $past(io_wdata_i[5], 3)) else $error("clip mode wrong");
  chk_foreign_read: assert property (
    io_rd_i && io_addr_i != 16'hBEE8 |=> io_rdata_o == 16'h0000) else $error("foreign read not zero");
  chk_narrow_beat: assert property (
    lo && !bpp32_i |=> pixel_valid_o && !pixel_wide_o && pixel_data_o == {16'h0000, $past(io_wdata_i)})
    else $error("narrow beat wrong");
  chk_wide_beat: assert property (
    lo && bpp32_i ##1 !io_wr_i ##1 hi && bpp32_i |=> pixel_valid_o && pixel_wide_o &&
    pixel_data_o == {$past(io_wdata_i), $past(io_wdata_i, 3)}) else $error("wide beat wrong");
  cov_bottom: cover property (w3);
  cov_wide: cover property (pixel_valid_o && pixel_wide_o);
  cov_read: cover property (io_rd_i && io_addr_i == 16'hBEE8);
endmodule
bind draw_engine_index_regs draw_engine_index_regs_properties u_props (
  .clock_i(clock_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
  .io_wdata_i(io_wdata_i), .bpp32_i(bpp32_i), .io_rdata_o(io_rdata_o), .clip_bottom_o(clip_bottom_o),
  .clip_right_o(clip_right_o), .mix_register_chooser_o(mix_register_chooser_o),
  .outside_clip_enable_o(outside_clip_enable_o), .edo_single_cycle_o(edo_single_cycle_o),
  .pixel_valid_o(pixel_valid_o), .pixel_wide_o(pixel_wide_o), .pixel_data_o(pixel_data_o));
`default_nettype wire

/* File: verif/host_bus_model.sv */
// Purpose: Host side of the register ports, one access at a time.
// Assumes: Accesses launched just after a rising edge.
// Notes:   Released address and data lines show the inverse of their last value; strobes drop low.
`default_nettype none
module host_bus_model (
  input  wire logic        clock_i,    // Clock.
  input  wire logic [15:0] io_rdata_i, // Readback.
  output logic      [15:0] io_addr_o,  // Address.
  output logic             io_wr_o,    // Write.
  output logic             io_rd_o,    // Read.
  output logic      [15:0] io_wdata_o  // Data.
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    io_addr_o = 16'h0000;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 16'h0000;
  end
  // Whole 16-bit accesses with an idle gap.
  task automatic access(input logic [15:0] a, input logic [15:0] d, input logic wr, output logic [15:0] q);
    @(posedge clock_i);
    #1;
    io_addr_o = a;
    io_wdata_o = d;
    io_wr_o = wr;
    io_rd_o = !wr;
    @(posedge clock_i);
    #1;
    q = io_rdata_i;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

/* File: verif/draw_engine_index_regs_tb_top.sv */
// Purpose: Self-checking bench of the index register bank.
// Assumes: Bench model tracks every field from the host writes.
// Notes:   Random stimulus from a fixed seed.
`default_nettype none
module draw_engine_index_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_i, nrst_i, io_mmio_i, bpp32_i, half_access_i, io_wr_i, io_rd_i, in_rect;
  logic        upper_word_flag_o, outside_clip_enable_o, colour_compare_enable_o, compare_polarity_o;
  logic        command_width_32_o, edo_single_cycle_o, draw_permit_o, update_permit_o, pixel_valid_o, pixel_wide_o;
  logic [15:0] io_addr_i, io_wdata_i, io_rdata_o, command_i, subsys_status_i, video_enable_i, q;
  logic [15:0] rb [0:2];
  logic [11:0] f [0:15];
  logic [11:0] px, py, clip_bottom_o, clip_right_o;
  logic [31:0] src, cmpc, pixel_data_o, r;
  logic [3:0]  rix;
  logic [3:0]  idx [0:5] = '{4'h3, 4'h4, 4'h5, 4'hA, 4'hD, 4'hE};
  logic [2:0]  destination_megabyte_o, source_megabyte_o;
  logic [1:0]  mix_register_chooser_o;
  integer      seed, n_errors, cmp_count;
  host_bus_model host (.clock_i(clock_i), .io_rdata_i(io_rdata_o), .io_addr_o(io_addr_i), .io_wr_o(io_wr_i),
    .io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i));
  draw_engine_index_regs uut (.clock_i(clock_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_mmio_i(io_mmio_i), .bpp32_i(bpp32_i),
    .half_access_i(half_access_i), .minor_count_i(rb[0]), .clip_top_i(rb[1]), .clip_left_i(rb[2]),
    .command_i(command_i), .subsys_status_i(subsys_status_i), .video_enable_i(video_enable_i),
    .pixel_x_i(px), .pixel_y_i(py), .source_colour_i(src), .compare_colour_i(cmpc), .io_rdata_o(io_rdata_o),
    .clip_bottom_o(clip_bottom_o), .clip_right_o(clip_right_o), .mix_register_chooser_o(mix_register_chooser_o),
    .destination_megabyte_o(destination_megabyte_o), .source_megabyte_o(source_megabyte_o),
    .upper_word_flag_o(upper_word_flag_o), .outside_clip_enable_o(outside_clip_enable_o),
    .colour_compare_enable_o(colour_compare_enable_o), .compare_polarity_o(compare_polarity_o),
    .command_width_32_o(command_width_32_o), .edo_single_cycle_o(edo_single_cycle_o),
    .draw_permit_o(draw_permit_o), .update_permit_o(update_permit_o), .pixel_valid_o(pixel_valid_o),
    .pixel_wide_o(pixel_wide_o), .pixel_data_o(pixel_data_o));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Writes reach the nibble's register, reserved bits dropped.
  function automatic logic [11:0] wmask(input logic [3:0] i);
    case (i)
      4'h3, 4'h4: wmask = 12'hFFF;
      4'hA: wmask = 12'h0C0;
      4'hD: wmask = 12'h077;
      4'hE: wmask = 12'h7BF;
      default: wmask = 12'h000;
    endcase
  endfunction
  function automatic logic [15:0] exp_rd(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2: exp_rd = rb[c];
      4'h3, 4'h4: exp_rd = {c, f[c]};
      4'h5: exp_rd = {4'hA, f[10]};
      4'h6: exp_rd = {4'hE, f[14]};
      4'h7: exp_rd = {3'b000, command_i[12:0]};
      4'h8: exp_rd = {4'h0, subsys_status_i[11:0]};
      4'h9: exp_rd = video_enable_i;
      4'hA: exp_rd = {4'hD, f[13]};
      default: exp_rd = 16'h0000;
    endcase
  endfunction
  task automatic iwr(input logic [3:0] i, input logic [11:0] d);
    host.access(16'hBEE8, {i, d}, 1'b1, q);
    f[i] = (f[i] & ~wmask(i)) | (d & wmask(i));
    if (i == 4'hF) rix = d[3:0];
  endtask
  task automatic sweep;
    iwr(4'hF, 12'h000);
    repeat (17) begin
      host.access(16'hBEE8, 16'h0000, 1'b0, q);
      // Masked codes and a stepping index.
      check("readback", q, exp_rd(rix));
      rix = rix + 4'h1;
    end
  endtask
  task automatic chk_out;
    logic [2:0] dw, sw;
    // A nonzero wide base wins over the narrow one.
    dw = (f[13][2:0] != 3'b000) ? f[13][2:0] : {1'b0, f[14][1:0]};
    sw = (f[13][6:4] != 3'b000) ? f[13][6:4] : {1'b0, f[14][3:2]};
    check("bottom", clip_bottom_o, f[3]);
    check("right", clip_right_o, f[4]);
    check("mix", mix_register_chooser_o, f[10][7:6]);
    check("dst", destination_megabyte_o, dw);
    check("src", source_megabyte_o, sw);
    check("upper", upper_word_flag_o, f[14][4]);
    check("outside", outside_clip_enable_o, f[14][5]);
    check("cmp", {colour_compare_enable_o, compare_polarity_o}, f[14][8:7]);
    check("cw32", command_width_32_o, f[14][9] & !io_mmio_i);
    check("edo", edo_single_cycle_o, !f[14][10]);
  endtask
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
  initial begin
    seed = 32'ha7b5;
    n_errors = 0;
    cmp_count = 0;
    {nrst_i, io_mmio_i, bpp32_i, half_access_i, px, py, src, cmpc, rix} = '0;
    for (int k = 0; k < 16; k++) f[k] = 12'h000;
    r = $random(seed);
    {command_i, subsys_status_i} = r;
    r = $random(seed);
    video_enable_i = r[15:0];
    rb[0] = {4'h0, r[27:16]};
    rb[1] = 16'h1000;
    rb[2] = 16'h2000;
    repeat (20) @(posedge clock_i);
    #1;
    nrst_i = 1'b1;
    check("edo_rst", edo_single_cycle_o, 1'b1);
    sweep();
    for (int it = 0; it < 24; it++) begin
      r = $random(seed);
      {io_mmio_i, half_access_i} = r[1:0];
      for (int k = 0; k < 6; k++) begin
        r = $random(seed);
        if (r[31]) r[6:4] = 3'b000;
        if (r[30]) r[2:0] = 3'b000;
        iwr(idx[k], r[11:0]);
      end
      repeat (3) @(posedge clock_i);
      #1;
      chk_out();
      r = $random(seed);
      rb[1] = {4'h1, r[11:0] & f[3]};
      rb[2] = {4'h2, r[23:12] & f[4]};
      px = (r[24] ? f[4] : rb[2][11:0]) + ((r[26:25] == 2'b00) ? 12'hFFF : {11'h0, r[25]});
      py = (r[27] ? f[3] : rb[1][11:0]) + ((r[29:28] == 2'b00) ? 12'hFFF : {11'h0, r[28]});
      src = $random(seed);
      cmpc = r[30] ? src : src ^ 32'h0000_0001;
      @(posedge clock_i);
      #1;
      in_rect = py >= rb[1][11:0] && py <= f[3] && px >= rb[2][11:0] && px <= f[4];
      check("draw", draw_permit_o, in_rect ^ f[14][5]);
      check("update", update_permit_o, !f[14][8] || (f[14][7] ? src == cmpc : src != cmpc));
    end
    sweep();
    iwr(4'hE, 12'h000);
    bpp32_i = 1'b1;
    half_access_i = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (k == 2) iwr(4'hE, 12'h210);
      repeat (3) @(posedge clock_i);
      #1;
      half_access_i = 1'b1;
      @(posedge clock_i);
      #1;
      half_access_i = 1'b0;
      if (!f[14][9]) f[14][4] = !f[14][4];
      repeat (2) @(posedge clock_i);
      #1;
      check("toggle", upper_word_flag_o, f[14][4]);
    end
    r = $random(seed);
    host.access(16'hE2EA, r[15:0], 1'b1, q);
    check("stray", pixel_valid_o, 1'b0);
    host.access(16'hE2E8, r[15:0], 1'b1, q);
    check("pending", pixel_valid_o, 1'b0);
    host.access(16'hE2EA, r[31:16], 1'b1, q);
    check("wide", {pixel_valid_o, pixel_wide_o}, 2'b11);
    check("wdata", pixel_data_o, r);
    bpp32_i = 1'b0;
    host.access(16'hE2E8, r[31:16], 1'b1, q);
    check("narrow", {pixel_valid_o, pixel_wide_o}, 2'b10);
    check("ndata", pixel_data_o, {16'h0000, r[31:16]});
    host.access(16'h1234, 16'h0000, 1'b0, q);
    check("foreign", q, 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
